// ### conv_scheduler.sv
/*
 Conversion scheduler: configuration registers for pressure and
 temperature rate and oversampling, the measurement control field,
 background and single conversion sequencing and result registers.
 Assumes a simple synchronous byte register port and a sensing front end
 that delivers its 24-bit result when the conversion time has elapsed.
*/
`timescale 1ns/10ps
// Functional notes
// [RULE_01] Pressure rate bits 6:4, 2^n per second
// [RULE_02] Rates apply only in background operation
// [RULE_03] Pressure oversampling bits 3:0, 1 to 128
// [RULE_04] Host shifts pressure result from code 0100
// [RULE_05] Pressure conversion 3.6 ms to 206.8 ms
// [RULE_06] Host keeps pressure timing within one second
// [RULE_07] Host keeps combined timing within one second
// [RULE_08] Temperature bit 7 selects sensor source
// [RULE_09] Host matches source to coefficient origin
// [RULE_10] Temperature rate bits 6:4, 2^n per second
// [RULE_11] Temperature oversampling bits 2:0, default single
// [RULE_12] Temperature oversampling codes 001-111 optional
// [RULE_13] Background starts each quantity per rate interval
// [RULE_14] Pressure bit 7 reads zero, writes ignored
// [RULE_15] Codes 101, 110, 111 start background
// [RULE_16] Codes 001, 010 start single conversion
// [RULE_17] Host sets shift above eight samples
// [RULE_18] Results are 24-bit, three bytes, MSB first
module conv_scheduler #(
   parameter int CONV_BASE = conv_sched_pkg::CONV_BASE_CYCLES,
   parameter int CONV_STEP = conv_sched_pkg::CONV_STEP_CYCLES,
   parameter int WINDOW = conv_sched_pkg::WINDOW_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [23:0] fe_result_i,
   output logic fe_start_o,
   output logic fe_is_temp_o,
   output logic [2:0] fe_oversample_o,
   output logic fe_temp_source_o
);
   localparam int W = conv_sched_pkg::CNT_W;

   // Conversion length in cycles for an oversampling code
   function automatic logic [W-1:0] conv_cycles(input logic [2:0] os);
      logic [W-1:0] steps;
      steps = (W'(1) << os) - W'(1);
      conv_cycles = W'(CONV_BASE) + W'(CONV_STEP) * steps;
   endfunction

   logic [7:0] press_setup;
   logic [7:0] temp_setup;
   logic [2:0] op_select;
   logic press_ready;
   logic temp_ready;
   logic press_pend;
   logic temp_pend;
   logic conv_is_temp;
   logic [W-1:0] conv_left;
   logic [23:0] press_result;
   logic [23:0] temp_result;
   conv_sched_pkg::sched_state_e state;
   conv_sched_pkg::sched_state_e next_state;
   logic press_tick;
   logic temp_tick;

   // Field views of the configuration registers
   wire [2:0] pressure_rate_sel = press_setup[6:4];
   wire [3:0] pressure_oversample_sel = press_setup[3:0];
   wire [2:0] temp_rate_sel = temp_setup[6:4];
   wire [2:0] temp_oversample_sel = temp_setup[2:0];
   wire temp_source_sel = temp_setup[conv_sched_pkg::TEMP_SOURCE_BIT];
   wire [2:0] conversion_op_select = op_select;

   // Register decode
   wire wr_press = reg_wr_i && (reg_addr_i == conv_sched_pkg::PRESS_SETUP_ADDR);
   wire wr_temp = reg_wr_i && (reg_addr_i == conv_sched_pkg::TEMP_SETUP_ADDR);
   wire wr_op = reg_wr_i && (reg_addr_i == conv_sched_pkg::CONVERSION_OP_SELECT_ADDR);
   wire rd_press_lo = reg_rd_i && (reg_addr_i == conv_sched_pkg::PRESS_RESULT_LO_ADDR);
   wire rd_temp_lo = reg_rd_i && (reg_addr_i == conv_sched_pkg::TEMP_RESULT_LO_ADDR);

   // Mode decode
   wire bg_press = (op_select == conv_sched_pkg::OP_BG_PRESS) ||
                   (op_select == conv_sched_pkg::OP_BG_BOTH); // RULE_15
   wire bg_temp = (op_select == conv_sched_pkg::OP_BG_TEMP) ||
                  (op_select == conv_sched_pkg::OP_BG_BOTH); // RULE_15
   wire cmd_press = wr_op && (reg_wdata_i[2:0] == conv_sched_pkg::OP_SINGLE_PRESS); // RULE_16
   wire cmd_temp = wr_op && (reg_wdata_i[2:0] == conv_sched_pkg::OP_SINGLE_TEMP); // RULE_16

   // Pending requests: ticks count only in background mode
   wire set_press = (press_tick && bg_press) || cmd_press; // RULE_02
   wire set_temp = (temp_tick && bg_temp) || cmd_temp; // RULE_02
   wire start_press = (state == conv_sched_pkg::ST_IDLE) && press_pend;
   wire start_temp = (state == conv_sched_pkg::ST_IDLE) && !press_pend && temp_pend;
   wire store_now = (state == conv_sched_pkg::ST_STORE);
   wire single_done = store_now && !bg_press && !bg_temp && (op_select != conv_sched_pkg::OP_IDLE);
   wire [2:0] start_os = start_press ? pressure_oversample_sel[2:0] :
                         temp_oversample_sel; // RULE_12

   // Read data selection
   wire [7:0] status_byte = {2'h0, temp_ready, press_ready, 1'b0, conversion_op_select};
   wire [7:0] next_rdata =
      (reg_addr_i == conv_sched_pkg::PRESS_RESULT_HI_ADDR) ? press_result[23:16] :
      (reg_addr_i == conv_sched_pkg::PRESS_RESULT_MID_ADDR) ? press_result[15:8] :
      (reg_addr_i == conv_sched_pkg::PRESS_RESULT_LO_ADDR) ? press_result[7:0] :
      (reg_addr_i == conv_sched_pkg::TEMP_RESULT_HI_ADDR) ? temp_result[23:16] :
      (reg_addr_i == conv_sched_pkg::TEMP_RESULT_MID_ADDR) ? temp_result[15:8] :
      (reg_addr_i == conv_sched_pkg::TEMP_RESULT_LO_ADDR) ? temp_result[7:0] :
      (reg_addr_i == conv_sched_pkg::PRESS_SETUP_ADDR) ? press_setup :
      (reg_addr_i == conv_sched_pkg::TEMP_SETUP_ADDR) ? temp_setup :
      (reg_addr_i == conv_sched_pkg::CONVERSION_OP_SELECT_ADDR) ? status_byte : 8'h00; // RULE_18

   // Interval tickers, one per quantity
   rate_ticker #(.WINDOW(WINDOW)) press_ticker (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .enable_i(bg_press),
      .rate_i(pressure_rate_sel),
      .tick_o(press_tick)
   );

   rate_ticker #(.WINDOW(WINDOW)) temp_ticker (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .enable_i(bg_temp),
      .rate_i(temp_rate_sel),
      .tick_o(temp_tick)
   );

   // Configuration registers; pressure bit 7 is held at zero
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         press_setup <= conv_sched_pkg::PRESS_SETUP_RESET;
         temp_setup <= conv_sched_pkg::TEMP_SETUP_RESET;
      end else begin
         if (wr_press) press_setup <= {1'b0, reg_wdata_i[6:0]}; // RULE_01 RULE_03 RULE_14
         if (wr_temp) begin // RULE_08 RULE_10 RULE_11
            temp_setup <= {reg_wdata_i[7:4], 1'b0, reg_wdata_i[2:0]};
         end
      end
   end

   // Measurement control; a finished single conversion returns to idle
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         op_select <= conv_sched_pkg::OP_SELECT_RESET;
      end else if (wr_op) begin
         op_select <= reg_wdata_i[2:0];
      end else if (single_done) begin
         op_select <= conv_sched_pkg::OP_IDLE; // RULE_16
      end
   end

   // Pending flags: a new request wins over the start that consumes one
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         press_pend <= 1'b0;
         temp_pend <= 1'b0;
      end else begin
         press_pend <= set_press || (press_pend && !start_press); // RULE_13
         temp_pend <= set_temp || (temp_pend && !start_temp); // RULE_13
      end
   end

   // Sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         conv_sched_pkg::ST_IDLE: begin
            if (start_press || start_temp) next_state = conv_sched_pkg::ST_CONV;
         end
         conv_sched_pkg::ST_CONV: begin
            if (conv_left == '0) next_state = conv_sched_pkg::ST_STORE;
         end
         default: begin
            next_state = conv_sched_pkg::ST_IDLE;
         end
      endcase
   end

   // Sequencer state, conversion timer and front end controls
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state <= conv_sched_pkg::ST_IDLE;
         conv_left <= '0;
         conv_is_temp <= 1'b0;
         fe_start_o <= 1'b0;
         fe_is_temp_o <= 1'b0;
         fe_oversample_o <= 3'h0;
         fe_temp_source_o <= 1'b0;
      end else begin
         state <= next_state;
         fe_start_o <= start_press || start_temp;
         if (start_press || start_temp) begin
            conv_left <= conv_cycles(start_os) - 1'b1; // RULE_05
            conv_is_temp <= start_temp;
            fe_is_temp_o <= start_temp;
            fe_oversample_o <= start_os;
            fe_temp_source_o <= temp_source_sel; // RULE_08
         end else if (conv_left != '0) begin
            conv_left <= conv_left - 1'b1;
         end
      end
   end

   // Results and ready flags; set wins over the clearing read
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         press_result <= 24'h000000;
         temp_result <= 24'h000000;
         press_ready <= 1'b0;
         temp_ready <= 1'b0;
         reg_rdata_o <= 8'h00;
      end else begin
         if (store_now && !conv_is_temp) press_result <= fe_result_i; // RULE_18
         if (store_now && conv_is_temp) temp_result <= fe_result_i; // RULE_18
         press_ready <= (store_now && !conv_is_temp) || (press_ready && !rd_press_lo);
         temp_ready <= (store_now && conv_is_temp) || (temp_ready && !rd_temp_lo);
         if (reg_rd_i) reg_rdata_o <= next_rdata;
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   logic [W-1:0] conv_age;
   logic [W-1:0] conv_expect;
   logic [W-1:0] tick_gap;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || fe_start_o) conv_age <= '0;
      else conv_age <= conv_age + 1'b1;
      if (!rst_n_i) conv_expect <= '0;
      else if (start_press || start_temp) conv_expect <= conv_cycles(start_os);
      if (!rst_n_i || press_tick || !bg_press) tick_gap <= '0;
      else tick_gap <= tick_gap + 1'b1;
   end

   press_reserved_a: assert property (press_setup[7] == 1'b0) // RULE_14
      else $error("pressure setup bit 7 not zero");
   press_rate_a: assert property ( // RULE_01
      wr_press |=> pressure_rate_sel == $past(reg_wdata_i[6:4]))
      else $error("pressure rate field not written");
   press_os_a: assert property ( // RULE_03
      wr_press |=> pressure_oversample_sel == $past(reg_wdata_i[3:0]))
      else $error("pressure oversampling field not written");
   temp_fields_a: assert property ( // RULE_08 RULE_10
      wr_temp |=> {temp_source_sel, temp_rate_sel} == $past(reg_wdata_i[7:4]))
      else $error("temperature source or rate not written");
   temp_os_a: assert property ( // RULE_11
      wr_temp |=> temp_oversample_sel == $past(reg_wdata_i[2:0]))
      else $error("temperature oversampling not written");
   single_start_a: assert property ( // RULE_16
      state == conv_sched_pkg::ST_IDLE && !press_pend && !temp_pend && cmd_press
      |=> ##1 fe_start_o && !fe_is_temp_o)
      else $error("single pressure conversion not started");
   bg_enter_a: assert property ( // RULE_15
      wr_op && reg_wdata_i[2:0] == conv_sched_pkg::OP_BG_BOTH |=> bg_press && bg_temp)
      else $error("background mode not entered");
   no_bg_tick_a: assert property ( // RULE_02
      !bg_press && !cmd_press && !press_pend |=> !press_pend)
      else $error("pressure request outside background mode");
   // Store cycle falls the full conversion length after the start pulse
   conv_len_a: assert property ( // RULE_05
      state == conv_sched_pkg::ST_STORE |-> conv_age == conv_expect - 1'b1)
      else $error("conversion length wrong");
   // A rate change restarts the interval, so its first tick is not timed
   tick_gap_a: assert property ( // RULE_13
      press_tick && $past(bg_press) && $past(pressure_rate_sel, 2) == pressure_rate_sel
      |-> tick_gap == (W'(WINDOW) >> pressure_rate_sel) - 1'b1)
      else $error("pressure interval wrong");
   // Read data is the result as it stood on the read edge
   result_order_a: assert property ( // RULE_18
      reg_rd_i && reg_addr_i == conv_sched_pkg::PRESS_RESULT_HI_ADDR
      |=> reg_rdata_o == $past(press_result[23:16]))
      else $error("pressure result MSB not returned");
endmodule

// ### conv_sched_pkg.sv
/*
 Constants for the pressure and temperature conversion scheduler: register
 offsets, field positions, reset values, control codes and timing counts.
 Assumes a single 25 MHz clock.
*/
package conv_sched_pkg;
   // Register offsets
   localparam logic [7:0] PRESS_RESULT_HI_ADDR = 8'h00;
   localparam logic [7:0] PRESS_RESULT_MID_ADDR = 8'h01;
   localparam logic [7:0] PRESS_RESULT_LO_ADDR = 8'h02;
   localparam logic [7:0] TEMP_RESULT_HI_ADDR = 8'h03;
   localparam logic [7:0] TEMP_RESULT_MID_ADDR = 8'h04;
   localparam logic [7:0] TEMP_RESULT_LO_ADDR = 8'h05;
   localparam logic [7:0] PRESS_SETUP_ADDR = 8'h06;
   localparam logic [7:0] TEMP_SETUP_ADDR = 8'h07;
   localparam logic [7:0] CONVERSION_OP_SELECT_ADDR = 8'h08;
   // Reset values
   localparam logic [7:0] PRESS_SETUP_RESET = 8'h00;
   localparam logic [7:0] TEMP_SETUP_RESET = 8'h00;
   localparam logic [2:0] OP_SELECT_RESET = 3'h0;
   // Field positions
   localparam int RATE_LSB = 4;
   localparam int TEMP_SOURCE_BIT = 7;
   localparam int PRESS_READY_BIT = 4;
   localparam int TEMP_READY_BIT = 5;
   // Operation codes of the measurement control field
   localparam logic [2:0] OP_IDLE = 3'h0;
   localparam logic [2:0] OP_SINGLE_PRESS = 3'h1;
   localparam logic [2:0] OP_SINGLE_TEMP = 3'h2;
   localparam logic [2:0] OP_BG_PRESS = 3'h5;
   localparam logic [2:0] OP_BG_TEMP = 3'h6;
   localparam logic [2:0] OP_BG_BOTH = 3'h7;
   // Timing
   localparam int CLK_HZ = 25000000;
   localparam int CLK_PER_US = CLK_HZ / 1000000;
   localparam int SINGLE_CONV_TIME_US = 3600;
   localparam int CONV_STEP_TIME_US = 1600;
   localparam int RATE_WINDOW_S = 1;
   localparam int CONV_BASE_CYCLES = SINGLE_CONV_TIME_US * CLK_PER_US;
   localparam int CONV_STEP_CYCLES = CONV_STEP_TIME_US * CLK_PER_US;
   localparam int WINDOW_CYCLES = RATE_WINDOW_S * CLK_HZ;
   localparam int CNT_W = 25;
   // Scheduler states, Gray coded along idle, convert, store
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CONV = 2'h1,
      ST_STORE = 2'h3
   } sched_state_e;
endpackage

// ### rate_ticker.sv
/*
 Interval ticker: while enabled, pulses once on enable and then every
 window divided by two to the power of the rate code.
 Assumes the window count fits in the counter width.
*/
`timescale 1ns/10ps
module rate_ticker #(
   parameter int WINDOW = conv_sched_pkg::WINDOW_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic [2:0] rate_i,
   output logic tick_o
);
   logic [conv_sched_pkg::CNT_W-1:0] count;
   logic [2:0] last_rate;
   wire [conv_sched_pkg::CNT_W-1:0] period = conv_sched_pkg::CNT_W'(WINDOW) >> rate_i;
   wire restart = !enable_i || (rate_i != last_rate);

   // Free count while enabled; a new rate starts a fresh interval
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || restart) begin
         count <= '0;
      end else if (count >= period - 1'b1) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         last_rate <= 3'h0;
      end else begin
         last_rate <= rate_i;
      end
   end

   assign tick_o = enable_i && !restart && (count == '0); // RULE_13
endmodule

// ### fe_model.sv
/*
 Behavioural sensing front end for the conversion scheduler bench.
 Assumes start and conversion settings arrive together, one clock.
*/
`timescale 1ns/10ps
module fe_model #(
   parameter int CONV_BASE = 10,
   parameter int CONV_STEP = 4
) (
   input wire logic clk_i,
   input wire logic start_i,
   input wire logic is_temp_i,
   input wire logic [2:0] oversample_i,
   input wire logic temp_source_i,
   output logic [23:0] result_o
);
   int count = -1;
   int conv = 0;
   logic [23:0] value = 24'h000000;
   logic flip = 1'b0;
   logic valid;
   // Conversion time grows with oversampling
   always @(posedge clk_i) begin
      flip <= ~flip;
      if (start_i) begin
         conv <= CONV_BASE + CONV_STEP * ((1 << oversample_i) - 1);
         value <= {7'h4E, is_temp_i, 4'h0, temp_source_i, oversample_i, 8'hB1};
         count <= 0;
      end else if (count >= 0 && count <= conv + 1) begin
         count <= count + 1;
      end else begin
         count <= -1;
      end
   end
   // Result is held only around its sampling edge, garbage otherwise
   assign valid = (count >= conv - 1) && (count <= conv + 1);
   assign result_o = valid ? value : ~value ^ {24{flip}};
endmodule

// ### tb.sv
/*
 Self-checking bench for the conversion scheduler.
 Assumes shortened timing parameters and the front end model beside it.
*/
`timescale 1ns/10ps
module tb;
   localparam int WIN = 2048;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [23:0] fe_result;
   logic fe_start, fe_is_temp, fe_src;
   logic [2:0] fe_os;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   conv_scheduler #(.CONV_BASE(10), .CONV_STEP(4), .WINDOW(WIN)) DUT (.clk_i(clk),
      .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .fe_result_i(fe_result), .fe_start_o(fe_start),
      .fe_is_temp_o(fe_is_temp), .fe_oversample_o(fe_os), .fe_temp_source_o(fe_src));
   fe_model #(.CONV_BASE(10), .CONV_STEP(4)) FE (.clk_i(clk), .start_i(fe_start),
      .is_temp_i(fe_is_temp), .oversample_i(fe_os), .temp_source_i(fe_src),
      .result_o(fe_result));
   // Clock and run-time ceiling
   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         $display("CHECK FAILED at %0t: %s", $time, msg);
         err_count++;
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #1 wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1 rd = 1'b0;
      d = rdata;
   endtask
   // Waits for a start pulse, returns its cycle or -1
   task automatic wait_start(input int lim, output int s);
      s = -1;
      for (int i = 0; i < lim && s < 0; i++) begin
         @(posedge clk);
         #2 if (fe_start === 1'b1) s = cyc;
      end
   endtask
   // Reset values, reserved bits, read-only and unmapped places
   task automatic reg_access();
      logic [7:0] d;
      int s;
      rd_reg(8'h06, d);
      chk(d === 8'h00, "pressure setup reset");
      rd_reg(8'h07, d);
      chk(d === 8'h00, "temp setup reset");
      rd_reg(8'h08, d);
      chk(d === 8'h00, "control reset");
      wr_reg(8'h06, 8'hFF);
      rd_reg(8'h06, d);
      chk(d === 8'h7F, "pressure setup");
      wr_reg(8'h07, 8'hFF);
      rd_reg(8'h07, d);
      chk(d === 8'hF7, "temp setup");
      wr_reg(8'h00, 8'hFF);
      rd_reg(8'h00, d);
      chk(d === 8'h00, "result write");
      rd_reg(8'h30, d);
      chk(d === 8'h00, "unmapped read");
      // Unused control code is stored but starts nothing; upper bits read-only
      wr_reg(8'h08, 8'hFC);
      rd_reg(8'h08, d);
      chk(d === 8'h04, "unused control code");
      wait_start(20, s);
      chk(s < 0, "unused code starts nothing");
      wr_reg(8'h08, 8'h00);
      wr_reg(8'h07, 8'h00);
   endtask
   // One commanded conversion with the highest rate code left in place
   task automatic single_conv(input logic t, input logic src, input logic [2:0] os);
      logic [7:0] d;
      logic [23:0] e;
      int s;
      int n;
      e = {7'h4E, t, 4'h0, src, os, 8'hB1};
      wr_reg(t ? 8'h07 : 8'h06, {t & src, 3'h7, 1'b0, os});
      wr_reg(8'h08, t ? 8'h02 : 8'h01);
      wait_start(8, s);
      chk(s >= 0 && fe_is_temp === t && fe_os === os, "start settings");
      chk(fe_src === src, "temp source");
      n = 0;
      do begin
         rd_reg(8'h08, d);
         n++;
      end while (d[t ? 5 : 4] !== 1'b1 && n < 400);
      n = cyc - s;
      chk(n >= 10 + 4 * ((1 << os) - 1) && n <= 15 + 4 * ((1 << os) - 1), "conv time");
      chk(d[2:0] === 3'h0, "control back to idle");
      for (int b = 0; b < 3; b++) begin
         rd_reg(8'(t ? 3 + b : b), d);
         chk(d === e[23 - 8 * b -: 8], "result byte");
      end
      rd_reg(8'h08, d);
      chk(d[t ? 5 : 4] === 1'b0, "ready cleared");
      wait_start(40, s);
      chk(s < 0, "no restart after single");
   endtask
   // Background pressure interval for one rate code
   task automatic bg_rate(input logic [2:0] r);
      int s0;
      int s1;
      wr_reg(8'h06, {1'b0, r, 4'h0});
      wr_reg(8'h08, 8'h05);
      wait_start(WIN + 40, s0);
      wait_start(WIN + 40, s0);
      wait_start(WIN + 40, s1);
      chk(s0 >= 0 && s1 - s0 == (WIN >> r), "background interval");
      wr_reg(8'h08, 8'h00);
      wait_start(40, s0);
   endtask
   // Mixed background modes, counting starts of each kind
   task automatic bg_mix(input logic [7:0] op, input int ep, input int et);
      int p = 0;
      int t = 0;
      wr_reg(8'h06, 8'h52);
      wr_reg(8'h07, 8'h41);
      wr_reg(8'h08, op);
      repeat (1024) begin
         @(posedge clk);
         #2 if (fe_start === 1'b1 && fe_is_temp === 1'b1) begin
            t++;
            chk(fe_os === 3'h1 && fe_src === 1'b0, "temp settings");
         end else if (fe_start === 1'b1) begin
            p++;
            chk(fe_os === 3'h2, "pressure settings");
         end
      end
      chk(p >= ep - 1 && p <= ep + 1, "pressure start count");
      chk(t >= et - 1 && t <= et + 1, "temp start count");
      wr_reg(8'h08, 8'h00);
      repeat (40) @(posedge clk);
      wait_start(600, p);
      chk(p < 0, "idle stops background");
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      reg_access();
      for (int i = 0; i < 8; i++) single_conv(1'b0, 1'b0, 3'(i));
      for (int i = 0; i < 8; i++) single_conv(1'b1, 1'(i), 3'(i));
      for (int r = 0; r < 8; r++) bg_rate(3'(r));
      bg_mix(8'h07, 16, 8);
      bg_mix(8'h06, 0, 8);
      bg_mix(8'h05, 16, 0);
      wrap_up();
   end
endmodule
